// file: logic/opsel_top.sv
// module: ahb-lite register file of output pin function selectors, pins 18..31
// Notes on behaviour
// - each register holds odd-pin selector at bits 13:8, even-pin at 5:0
// - nonzero selector value n below NUM_FUNCS routes peripheral output n onto that pin; zero or a larger value leaves the pin on port_out
// - bits 15:14 and 7:6 are unimplemented and read zero
// - selector bits are read/write and clear to zero at reset
// - in 64-pin variant, pin 31 selector is absent and reads zero
// - registers 9 to 15 cover pins 18 to 31 in ascending order
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
module opsel_top
  import opsel_pkg::*;
#(
  parameter int NUM_FUNCS = 64,
  parameter bit PIN64_VARIANT = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic [NUM_FUNCS-1:0] periph_out,
  input wire logic [OPSEL_NUM_PINS-1:0] port_out,
  output logic [OPSEL_NUM_PINS-1:0] remappable_pin,
  output logic [OPSEL_NUM_PINS-1:0] pin_is_mapped,
  output logic [OPSEL_NUM_PINS*OPSEL_SEL_W-1:0] pin_function_sel
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [OPSEL_NUM_PINS-1:0][OPSEL_SEL_W-1:0] sel;
    logic wr_pend;
    logic [2:0] wr_idx;
    logic [31:0] rdata;
  } opsel_state_t;

  opsel_state_t st;
  opsel_state_t next_st;

  // word index into the selector bank, or 7 when unmapped
  function automatic logic [2:0] opsel_index(input logic [31:0] a);
    logic [31:0] off;
    off = a - {20'h0_0000, OPSEL_BASE_OFFSET};
    if (off[31:2] < 30'(OPSEL_NUM_REGS)) begin
      return off[4:2];
    end
    return 3'h7;
  endfunction : opsel_index

  // can software hold a nonzero value in this pin's selector
  function automatic logic opsel_pin_impl(input int pin);
    return !(PIN64_VARIANT && pin == OPSEL_NUM_PINS - 1);
  endfunction : opsel_pin_impl

  logic take;
  logic [2:0] acc_idx;
  logic [31:0] rd_word;
  assign take = hsel && hready && (htrans == OPSEL_HTRANS_NONSEQ || htrans == OPSEL_HTRANS_SEQ);
  assign acc_idx = opsel_index(haddr);

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    if (acc_idx != 3'h7) begin
      rd_word[OPSEL_EVEN_LSB +: OPSEL_SEL_W] = st.sel[2*acc_idx];
      rd_word[OPSEL_ODD_LSB +: OPSEL_SEL_W] = st.sel[2*acc_idx+1];
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    // write data arrives in the data phase, one cycle after the address
    if (st.wr_pend && st.wr_idx != 3'h7) begin
      next_st.sel[2*st.wr_idx] = hwdata[OPSEL_EVEN_LSB +: OPSEL_SEL_W];
      next_st.sel[2*st.wr_idx+1] = hwdata[OPSEL_ODD_LSB +: OPSEL_SEL_W];
    end
    for (int p = 0; p < OPSEL_NUM_PINS; p++) begin
      if (!opsel_pin_impl(p)) begin
        next_st.sel[p] = OPSEL_SEL_NONE;
      end
    end
    next_st.wr_pend = take && hwrite;
    next_st.wr_idx = acc_idx;
    next_st.rdata = (take && !hwrite) ? rd_word : 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = OPSEL_HRESP_OKAY;

  // ****************************************
  // pin multiplexer
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < OPSEL_NUM_PINS; g++) begin : g_pin
      logic hit;
      // out-of-range values fall back to the port rather than float
      assign hit = st.sel[g] != OPSEL_SEL_NONE && 32'(st.sel[g]) < NUM_FUNCS;
      assign pin_is_mapped[g] = hit;
      assign remappable_pin[g] = hit ? periph_out[st.sel[g]] : port_out[g];
      assign pin_function_sel[g*OPSEL_SEL_W +: OPSEL_SEL_W] = st.sel[g];
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    take && hwrite && acc_idx == 3'h0 ##1 1'b1 |=>
      st.sel[0] == $past(hwdata[5:0]) && st.sel[1] == $past(hwdata[13:8]))
    else $error("selector write not stored");
  a_read_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[15:14] == 2'h0 && hrdata[7:6] == 2'h0 && hrdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");
  a_read_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && acc_idx == 3'h1 && !st.wr_pend |=>
      hrdata[5:0] == $past(st.sel[2]) && hrdata[13:8] == $past(st.sel[3]))
    else $error("read fields misplaced");
  a_pin31_absent: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[OPSEL_NUM_PINS-1] != 6'h00 |-> !PIN64_VARIANT)
    else $error("pin 31 selector present in small variant");
  a_port_default: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[4] == 6'h00 |-> remappable_pin[4] == port_out[4])
    else $error("unmapped pin not on port");
  a_route_func: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[12] == 6'h11 |-> remappable_pin[12] == periph_out[17])
    else $error("pin not driven by selected function");
  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && acc_idx == 3'h7 |=> hrdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");
  a_hold_value: assert property (@(posedge hclk) disable iff (!hresetn)
    !st.wr_pend |=> $stable(st.sel[0]))
    else $error("selector changed without write");

  // ****************************************
  // reset and bus checks
  // ****************************************
  // no disable here: the check must see the very edge that reset lets go
  a_reset_clear: assert property (@(posedge hclk)
    $rose(hresetn) |-> st.sel == '0 && hrdata == 32'h0000_0000)
    else $error("selectors not cleared by reset");
  a_read_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data left on bus outside data phase");
  a_read_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && acc_idx == 3'h0) |=>
      hrdata[5:0] == $past(st.sel[0]) && hrdata[13:8] == $past(st.sel[1]))
    else $error("first register read misplaced");
  a_read_mid: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && acc_idx == 3'h3) |=>
      hrdata[5:0] == $past(st.sel[6]) && hrdata[13:8] == $past(st.sel[7]))
    else $error("middle register read misplaced");
  a_read_last: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && acc_idx == 3'h6) |=>
      hrdata[5:0] == $past(st.sel[12]) && hrdata[13:8] == $past(st.sel[13]))
    else $error("last register read misplaced");

  // ****************************************
  // selector store checks
  // ****************************************
  a_write_mid: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && hwrite && acc_idx == 3'h3) ##1 1'b1 |=>
      st.sel[6] == $past(hwdata[5:0]) && st.sel[7] == $past(hwdata[13:8]))
    else $error("middle register write not stored");
  a_write_last: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && hwrite && acc_idx == 3'h6) ##1 1'b1 |=>
      st.sel[12] == $past(hwdata[5:0]) &&
      (PIN64_VARIANT || st.sel[13] == $past(hwdata[13:8])))
    else $error("last register write not stored");
  a_write_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && hwrite && acc_idx == 3'h7) ##1 1'b1 |=> $stable(st.sel))
    else $error("unmapped write changed a selector");
  a_hold_last: assert property (@(posedge hclk) disable iff (!hresetn)
    !st.wr_pend |=> $stable(st.sel[OPSEL_NUM_PINS-1]))
    else $error("last selector changed without write");

  // ****************************************
  // pin routing checks
  // ****************************************
  a_route_even: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[0] == 6'h05 |-> remappable_pin[0] == periph_out[5])
    else $error("first pin not driven by selected function");
  a_mapped_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[0] == 6'h05 |-> pin_is_mapped[0])
    else $error("selected pin not flagged as mapped");
  a_first_port: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[0] == 6'h00 |-> remappable_pin[0] == port_out[0])
    else $error("unmapped first pin not on port");
  a_last_port: assert property (@(posedge hclk) disable iff (!hresetn)
    st.sel[OPSEL_NUM_PINS-1] == 6'h00 |->
      remappable_pin[OPSEL_NUM_PINS-1] == port_out[OPSEL_NUM_PINS-1] &&
      !pin_is_mapped[OPSEL_NUM_PINS-1])
    else $error("unmapped last pin not on port");

  // ****************************************
  // coverage
  // ****************************************
  c_write: cover property (@(posedge hclk) take && hwrite);
  c_read: cover property (@(posedge hclk) take && !hwrite && acc_idx == 3'h6);
  c_mapped: cover property (@(posedge hclk) pin_is_mapped[OPSEL_NUM_PINS-2]);
  c_reset_release: cover property (@(posedge hclk) $rose(hresetn));
  c_write_unmapped: cover property (@(posedge hclk) take && hwrite && acc_idx == 3'h7);

endmodule : opsel_top

// file: logic/opsel_pkg.sv
// package: register map and field layout for the output pin function selectors
package opsel_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int OPSEL_FIRST_REG = 9;
  localparam int OPSEL_LAST_REG = 15;
  localparam int OPSEL_NUM_REGS = OPSEL_LAST_REG - OPSEL_FIRST_REG + 1;
  localparam int OPSEL_FIRST_PIN = 18;
  localparam int OPSEL_NUM_PINS = 2 * OPSEL_NUM_REGS;
  // byte offset of output_pin_select_9; later registers follow one word apart
  localparam logic [11:0] OPSEL_BASE_OFFSET = 12'h000;
  localparam int OPSEL_ADDR_W = 12;
  // ****************************************
  // field layout
  // ****************************************
  localparam int OPSEL_SEL_W = 6;
  localparam int OPSEL_EVEN_LSB = 0;
  localparam int OPSEL_ODD_LSB = 8;
  localparam logic [5:0] OPSEL_SEL_RESET = 6'h00;
  // zero means no peripheral: pin stays under port control
  localparam logic [5:0] OPSEL_SEL_NONE = 6'h00;
  // ****************************************
  // bus encodings
  // ****************************************
  localparam logic [1:0] OPSEL_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] OPSEL_HTRANS_SEQ = 2'h3;
  localparam logic [1:0] OPSEL_HRESP_OKAY = 2'h0;
endpackage : opsel_pkg

// file: bench/opsel_top_tb_top.sv
// testbench: register access and pin routing checks for the output pin function selectors
module opsel_top_tb_top
  import opsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic [1:0] htrans = 2'h0, hresp;
  logic [63:0] periph_out = 64'h5A3C_9F06_E1B2_7D48;
  logic [13:0] port_out = 14'h2D96, remappable_pin, pin_is_mapped;
  logic [83:0] pin_function_sel;
  logic [5:0] exp_sel [14];
  int err_count = 0, compares = 0;
  always #4 hclk = ~hclk;
  opsel_top u_opsel_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .periph_out(periph_out),
    .port_out(port_out), .remappable_pin(remappable_pin), .pin_is_mapped(pin_is_mapped),
    .pin_function_sel(pin_function_sel));
  // ****************************************
  // shared helpers
  // ****************************************
  function automatic logic [31:0] ra(input int k);
    return {20'h0_0000, OPSEL_BASE_OFFSET} + 32'(4 * k);
  endfunction : ra
  task automatic chk(input string nm, input logic [83:0] e, input logic [83:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
      err_count++;
    end
  endtask : chk
  // single transfer; idle in the data phase so transfers never overlap
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= OPSEL_HTRANS_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("response", 84'(OPSEL_HRESP_OKAY), 84'(hresp));
  endtask : xfer
  task automatic chk_pins();
    logic [83:0] e_fs;
    logic [13:0] e_map, e_pin;
    // look mid-cycle, hand back on a rising edge for the next driver
    @(negedge hclk);
    for (int p = 0; p < 14; p++) begin
      e_fs[6*p +: 6] = exp_sel[p];
      e_map[p] = (exp_sel[p] != OPSEL_SEL_NONE);
      e_pin[p] = e_map[p] ? periph_out[exp_sel[p]] : port_out[p];
    end
    chk("selectors", e_fs, pin_function_sel);
    chk("mapped", 84'(e_map), 84'(pin_is_mapped));
    chk("pins", 84'(e_pin), 84'(remappable_pin));
    @(posedge hclk);
  endtask : chk_pins
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int k = 0; k < 7; k++) begin
      xfer(1'b0, ra(k), 32'h0000_0000);
      chk("reset value", 84'h0, 84'(r));
      exp_sel[2*k] = 6'h00;
      exp_sel[2*k+1] = 6'h00;
    end
    chk_pins();
  endtask : t_reset
  task automatic t_fields();
    for (int k = 0; k < 7; k++) begin
      xfer(1'b1, ra(k), 32'hFFFF_FFFF);
      xfer(1'b0, ra(k), 32'h0000_0000);
      chk("unimplemented bits", 84'h3F3F, 84'(r));
      exp_sel[2*k] = 6'(2 * k + 5);
      exp_sel[2*k+1] = 6'(2 * k + 40);
      xfer(1'b1, ra(k), {18'h0_0000, exp_sel[2*k+1], 2'h0, exp_sel[2*k]});
      xfer(1'b0, ra(k), 32'h0000_0000);
      chk("readback", 84'({exp_sel[2*k+1], 2'h0, exp_sel[2*k]}), 84'(r));
    end
  endtask : t_fields
  task automatic t_route();
    chk_pins();
    periph_out <= ~periph_out;
    chk_pins();
    xfer(1'b1, ra(0), 32'h0000_0000);
    exp_sel[0] = 6'h00;
    exp_sel[1] = 6'h00;
    chk_pins();
  endtask : t_route
  task automatic t_unmapped();
    xfer(1'b1, ra(7), 32'h0000_3F3F);
    xfer(1'b0, ra(7), 32'h0000_0000);
    chk("unmapped read", 84'h0, 84'(r));
    chk_pins();
    xfer(1'b0, ra(6), 32'h0000_0000);
    chk("last register", 84'({exp_sel[13], 2'h0, exp_sel[12]}), 84'(r));
  endtask : t_unmapped
  // second reset in mid-run, with selectors left nonzero by earlier scenarios
  task automatic t_rerun();
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
  endtask : t_rerun
  task automatic final_report();
    $display("checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_fields();
    t_route();
    t_unmapped();
    t_rerun();
    final_report();
  end
  // bus transfers here take a few hundred cycles at most
  initial begin
    #20_000;
    err_count++;
    final_report();
  end
endmodule : opsel_top_tb_top
